/* design/pms_pkg.sv */
// package for the power mode sequencer: constants, types and the rule summary
// Function
// RQ1 - after any reset every clock runs; software may gate peripheral clocks individually
// RQ2 - idle stops only the core clock; any system interrupt restarts it
// RQ3 - sleep stops most clocks, keeps power; wake without reset unless reset source
// RQ4 - wake sources selectable by software; power button always wakes
// RQ5 - keyboard/mouse, Ethernet and USB controllers can wake the always-on domain
// RQ6 - suspend stops all clocks but the real-time clock; switch power enable drops
// RQ7 - waking from suspend resets powered-down logic before it runs again
// RQ8 - shutdown equals suspend, apart from a status flag read at next startup
// RQ9 - switch power enable held low while resume reset is asserted
// RQ10 - power good alone does not release the system reset
// RQ11 - button active low when strapped manual, active high when strapped automatic
// RQ12 - the button is pressed low for at least 180 us and at most 4 s
// RQ13 - a button held for 4 s forces a shutdown; the code counts the long press only when strapped manual
// RQ14 - core rail enable rises 180 to 220 us after the button goes low
// RQ15 - software requests idle, sleep, suspend or shutdown; device then acts on it
package pms_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PRESS_MIN_US = 180;
  localparam int unsigned RAIL_MAX_US = 220;
  localparam int unsigned FORCE_OFF_S = 4;
  // enable rises at 200 us: inside the 180..220 us window
  localparam int unsigned RAIL_DLY_US = 200;
  localparam int unsigned RAIL_CYC = RAIL_DLY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RAIL_MIN_CYC = (PRESS_MIN_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RAIL_MAX_CYC = (RAIL_MAX_US * (CLK_HZ / 1_000_000));
  localparam longint unsigned FORCE_CYC = longint'(FORCE_OFF_S) * longint'(CLK_HZ);
  localparam int unsigned WAKE_RST_CYC = 16;
  localparam int unsigned NUM_WAKE = 3;
  localparam int unsigned NUM_PCLK = 8;
  localparam logic [NUM_PCLK-1:0] PCLK_RST = 8'hFF;

  typedef enum logic [2:0]
  {
    PMS_REQ_NONE = 3'h0,
    PMS_REQ_IDLE = 3'h1,
    PMS_REQ_SLEEP = 3'h2,
    PMS_REQ_SUSPEND = 3'h3,
    PMS_REQ_SHUTDOWN = 3'h4
  } pms_req_t;

  typedef struct packed
  {
    logic core;
    logic [NUM_PCLK-1:0] periph;
  } pms_clk_en_t;

  typedef struct packed
  {
    logic kbd_mouse;
    logic ethernet;
    logic usb;
  } pms_wake_t;
endpackage

/* design/pms_count.sv */
// cycle counter that reports when a level has held for a given count
`timescale 1ns/1ps
module pms_count
  import pms_pkg::*;
#(
  parameter int unsigned W = 28,
  parameter logic [W-1:0] LIMIT = 28'h1
)
(
  input wire logic clk, // clock
  input wire logic rst, // synchronous reset
  input wire logic run, // counts while high, clears when low
  output logic done // high once run has held for LIMIT cycles
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst || !run)
      cnt_q <= '0;
    else if (cnt_q != LIMIT)
      cnt_q <= cnt_q + W'(1);
  end

  assign done = run && (cnt_q == LIMIT);
endmodule // pms_count

/* design/pms_sequencer.sv */
// power mode sequencer: modes, clock gating, wake handling and rail enables
`timescale 1ns/1ps
module pms_sequencer
  import pms_pkg::*;
#(
  parameter int unsigned RAIL_CYCLES = RAIL_CYC,
  parameter longint unsigned FORCE_CYCLES = FORCE_CYC
)
(
  input wire logic MCLK, // suspend domain clock, 40 MHz
  input wire logic SYS_RST, // synchronous reset, active high
  input wire logic RESUME_RESET_N, // resume reset, active low
  input wire logic POWER_GOOD, // switch rails good
  input wire logic POWER_BUTTON_N, // power button pin
  input wire logic AUTO_ON_STRAP, // strap level: 1 auto power on
  input wire pms_req_t MODE_REQ, // software mode request
  input wire logic MODE_REQ_VALID, // one-cycle request strobe
  input wire logic [NUM_PCLK-1:0] PCLK_GATE_EN, // software peripheral clock enables
  input wire pms_wake_t WAKE_SEL, // software wake source enables
  input wire pms_wake_t WAKE_EVT, // wake events from always-on controllers
  input wire logic SYS_IRQ, // any system interrupt
  input wire logic RESET_WAKE, // wake source that itself demands a reset
  output logic MODE_REQ_READY, // request accepted this cycle
  output pms_clk_en_t CLK_EN, // clock enables
  output logic SWITCH_POWER_ENABLE, // switch domain power enable
  output logic CORE_RAIL_POWER_ENABLE, // core rail enable
  output logic SWITCH_RESET, // reset to switch domain logic
  output logic SHUTDOWN_FLAG, // last power down was a shutdown
  output logic [4:0] MODE_STATE // current mode, one-hot
);
  typedef enum logic [4:0]
  {
    S_NORMAL = 5'h01,
    S_IDLE = 5'h02,
    S_SLEEP = 5'h04,
    S_OFF = 5'h08,
    S_RAMP = 5'h10
  } pms_state_t;

  pms_state_t state_q;
  pms_state_t state_d;
  logic auto_q;
  logic rsm_q;
  logic btn_act;
  logic btn_prev_q;
  logic btn_fall;
  logic rail_run_q;
  logic rail_done;
  logic force_off;
  logic wake;
  logic rst_all;
  logic sw_rst_q;
  logic [4:0] rst_cnt_q;
  logic shut_q;
  logic sw_pwr_q;
  logic rail_q;
  pms_clk_en_t clk_q;

  assign rst_all = SYS_RST || !RESUME_RESET_N;

  // strap caught by the clock while resume reset is low, held afterwards
  always_ff @(posedge MCLK)
  begin
    rsm_q <= RESUME_RESET_N;
    if (!RESUME_RESET_N)
      auto_q <= AUTO_ON_STRAP;
  end

  assign btn_act = auto_q ? POWER_BUTTON_N : !POWER_BUTTON_N; // [RQ11]

  always_ff @(posedge MCLK)
  begin
    if (rst_all)
      btn_prev_q <= 1'b0;
    else
      btn_prev_q <= btn_act;
  end

  assign btn_fall = btn_act && !btn_prev_q;

  // core rail delay: only when the rail is off and the button is pressed
  always_ff @(posedge MCLK)
  begin
    if (rst_all || rail_done)
      rail_run_q <= 1'b0;
    else if (btn_fall && !rail_q)
      rail_run_q <= 1'b1;
  end

  pms_count #(.W(16), .LIMIT(16'(RAIL_CYCLES))) u_rail_dly
  (
    .clk(MCLK),
    .rst(rst_all),
    .run(rail_run_q),
    .done(rail_done)
  );

  // long press; counted on the pin level so a press under the window is not stretched
  pms_count #(.W(28), .LIMIT(28'(FORCE_CYCLES))) u_force
  (
    .clk(MCLK),
    .rst(rst_all),
    .run(btn_act && !auto_q),
    .done(force_off)
  );

  // button wakes regardless of selection; the rest is software gated
  assign wake = btn_fall || |(WAKE_SEL & WAKE_EVT); // [RQ4] [RQ5]
  assign MODE_REQ_READY = MODE_REQ_VALID && (state_q == S_NORMAL) && !force_off; // [RQ15]

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_NORMAL:
      begin
        if (force_off)
          state_d = S_OFF; // [RQ13]
        else if (MODE_REQ_READY)
        begin
          case (MODE_REQ)
            PMS_REQ_IDLE: state_d = S_IDLE;
            PMS_REQ_SLEEP: state_d = S_SLEEP;
            PMS_REQ_SUSPEND, PMS_REQ_SHUTDOWN: state_d = S_OFF; // [RQ8]
            default: state_d = S_NORMAL;
          endcase
        end
      end
      S_IDLE:
        if (force_off)
          state_d = S_OFF;
        else if (SYS_IRQ)
          state_d = S_NORMAL; // [RQ2]
      S_SLEEP:
        if (force_off)
          state_d = S_OFF;
        else if (wake)
          state_d = S_NORMAL; // [RQ3]
      S_OFF:
        if (wake && !force_off)
          state_d = S_RAMP;
      S_RAMP:
        // hold the switch domain in reset until its supply reports good and the wake reset count reaches WAKE_RST_CYC
        if (POWER_GOOD && rst_cnt_q == 5'(WAKE_RST_CYC))
          state_d = S_NORMAL; // [RQ7] [RQ10]
      default: state_d = S_NORMAL;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (rst_all)
      state_q <= S_NORMAL;
    else
      state_q <= state_d;
  end

  always_ff @(posedge MCLK)
  begin
    if (rst_all)
      shut_q <= 1'b0;
    else if (force_off && state_q != S_OFF && state_q != S_RAMP)
      shut_q <= 1'b1; // [RQ13]
    else if (state_q == S_NORMAL && MODE_REQ_READY && MODE_REQ == PMS_REQ_SHUTDOWN)
      shut_q <= 1'b1; // [RQ8]
    else if (state_q == S_NORMAL && MODE_REQ_READY && MODE_REQ == PMS_REQ_SUSPEND)
      shut_q <= 1'b0;
  end

  // powered-down logic sits in reset through the whole ramp
  always_ff @(posedge MCLK)
  begin
    if (rst_all)
      rst_cnt_q <= '0;
    else if (state_q != S_RAMP)
      rst_cnt_q <= '0;
    else if (rst_cnt_q != 5'(WAKE_RST_CYC))
      rst_cnt_q <= rst_cnt_q + 5'h01;
  end

  always_ff @(posedge MCLK)
  begin
    if (rst_all)
      sw_rst_q <= 1'b1;
    else
      sw_rst_q <= (state_d == S_OFF) || (state_d == S_RAMP)
        || (RESET_WAKE && state_q == S_SLEEP && wake); // [RQ3] [RQ7]
  end

  always_ff @(posedge MCLK)
  begin
    if (rst_all)
      sw_pwr_q <= 1'b0; // [RQ9]
    else
      sw_pwr_q <= (state_d != S_OFF); // [RQ6]
  end

  always_ff @(posedge MCLK)
  begin
    if (rst_all)
      rail_q <= 1'b0;
    else if (state_d == S_OFF)
      rail_q <= 1'b0;
    else if (rail_done || (auto_q && rsm_q && state_q == S_NORMAL))
      rail_q <= 1'b1; // [RQ14]
  end

  always_ff @(posedge MCLK)
  begin
    if (rst_all)
    begin
      clk_q.core <= 1'b1; // [RQ1]
      clk_q.periph <= PCLK_RST;
    end
    else
    begin
      case (state_d)
        S_NORMAL:
        begin
          clk_q.core <= 1'b1;
          clk_q.periph <= PCLK_GATE_EN; // [RQ1]
        end
        S_IDLE:
        begin
          clk_q.core <= 1'b0; // [RQ2]
          clk_q.periph <= PCLK_GATE_EN;
        end
        default:
        begin
          clk_q.core <= 1'b0; // [RQ3] [RQ6]
          clk_q.periph <= '0;
        end
      endcase
    end
  end

  assign CLK_EN = clk_q;
  assign SWITCH_POWER_ENABLE = sw_pwr_q;
  assign CORE_RAIL_POWER_ENABLE = rail_q;
  assign SWITCH_RESET = sw_rst_q;
  assign SHUTDOWN_FLAG = shut_q;
  assign MODE_STATE = state_q;

  a_pwr_in_reset: assert property (@(posedge MCLK) // [RQ9]
    !RESUME_RESET_N |=> !SWITCH_POWER_ENABLE)
    else $error("switch power on during resume reset");
  a_idle_core_off: assert property (@(posedge MCLK) disable iff (rst_all) // [RQ2]
    state_q == S_IDLE |-> !CLK_EN.core)
    else $error("core clock runs in idle");
  a_off_no_pwr: assert property (@(posedge MCLK) disable iff (rst_all) // [RQ6]
    state_q == S_OFF |-> !SWITCH_POWER_ENABLE && CLK_EN == '0)
    else $error("power or clock on in suspend");
  a_ramp_reset: assert property (@(posedge MCLK) disable iff (rst_all) // [RQ7]
    state_q == S_RAMP |-> SWITCH_RESET)
    else $error("no reset while waking from suspend");
  a_pg_alone: assert property (@(posedge MCLK) disable iff (rst_all) // [RQ10]
    $rose(state_q == S_NORMAL) && $past(state_q) == S_RAMP
    |-> $past(rst_cnt_q) == 5'(WAKE_RST_CYC) && $past(POWER_GOOD))
    else $error("left reset on power good alone");
  a_btn_wakes: assert property (@(posedge MCLK) disable iff (rst_all) // [RQ4]
    state_q == S_SLEEP && btn_fall && !force_off |=> state_q == S_NORMAL)
    else $error("button did not wake");
  a_force_off: assert property (@(posedge MCLK) disable iff (rst_all) // [RQ13]
    force_off && state_q != S_OFF && state_q != S_RAMP
    |=> state_q == S_OFF && SHUTDOWN_FLAG)
    else $error("long press did not shut down");
  a_shut_flag: assert property (@(posedge MCLK) disable iff (rst_all) // [RQ8]
    MODE_REQ_READY && MODE_REQ == PMS_REQ_SHUTDOWN |=> SHUTDOWN_FLAG && state_q == S_OFF)
    else $error("shutdown flag not set");
  a_rail_delay: assert property (@(posedge MCLK) disable iff (rst_all) // [RQ14]
    $rose(rail_run_q) |-> rail_run_q [*8])
    else $error("core rail delay cut short");
  a_reset_clocks: assert property (@(posedge MCLK) // [RQ1]
    $past(rst_all) |-> CLK_EN.core && CLK_EN.periph == PCLK_RST)
    else $error("clocks not all on after reset");
endmodule // pms_sequencer

/* test/pms_partner.sv */
// behavioural model of the external regulators and the power button
`timescale 1ns/1ps
module pms_partner
#(
  parameter int PG_DLY = 4,
  parameter int MIN_PRESS = 8,
  parameter int MAX_PRESS = 120
)
(
  input wire logic clk, // suspend clock
  input wire logic strap, // 1 when strapped for auto power on
  input wire logic sw_en, // switch power enable from the block
  output logic pg = 1'b0, // switch rails good
  output logic btn // power button pin
);
  int n = 0;
  logic pressed = 1'b0;

  // rails ramp a few cycles after enable but collapse at once when it drops
  always @(posedge clk)
  begin
    n <= sw_en ? ((n < PG_DLY) ? n + 1 : n) : 0;
    pg <= sw_en && (n >= PG_DLY);
  end

  assign btn = pressed ^ ~strap;

  // a press is never shorter or longer than the button allows
  task automatic press(input int len);
    int k;
    k = (len < MIN_PRESS) ? MIN_PRESS : ((len > MAX_PRESS) ? MAX_PRESS : len);
    @(posedge clk);
    pressed <= 1'b1;
    repeat (k) @(posedge clk);
    pressed <= 1'b0;
  endtask
endmodule // pms_partner

/* test/tb.sv */
// self-checking bench for the power mode sequencer
`timescale 1ns/1ps
module tb
  import pms_pkg::*;
;
  localparam int RAIL = 20;
  localparam int FORCE = 100;
  // rails report good only after the wake reset count has run out
  localparam int PG = 24;
  typedef struct packed
  {
    pms_req_t req;
    logic [4:0] st;
    logic [8:0] ck;
    logic sw;
    logic flag;
    logic [1:0] wk;
    logic [2:0] wsel;
  } pms_row_t;
  // wk: 0 interrupt, 1 selected wake event, 2 power button
  pms_row_t rows [5] = '{
    '{PMS_REQ_IDLE, 5'h02, 9'h0A5, 1'b1, 1'b0, 2'h0, 3'h0},
    '{PMS_REQ_SLEEP, 5'h04, 9'h000, 1'b1, 1'b0, 2'h1, 3'h2},
    '{PMS_REQ_SLEEP, 5'h04, 9'h000, 1'b1, 1'b0, 2'h2, 3'h0},
    '{PMS_REQ_SHUTDOWN, 5'h08, 9'h000, 1'b0, 1'b1, 2'h1, 3'h1},
    '{PMS_REQ_SUSPEND, 5'h08, 9'h000, 1'b0, 1'b0, 2'h1, 3'h4}};
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic RESUME_RESET_N = 1'b0;
  logic AUTO_ON_STRAP = 1'b0;
  logic MODE_REQ_VALID = 1'b0;
  logic SYS_IRQ = 1'b0;
  logic RESET_WAKE = 1'b0;
  pms_req_t MODE_REQ = PMS_REQ_NONE;
  logic [7:0] PCLK_GATE_EN = 8'hA5;
  pms_wake_t WAKE_SEL = 3'h0;
  pms_wake_t WAKE_EVT = 3'h0;
  logic POWER_GOOD, POWER_BUTTON_N, MODE_REQ_READY, SWITCH_POWER_ENABLE;
  logic CORE_RAIL_POWER_ENABLE, SWITCH_RESET, SHUTDOWN_FLAG, seen;
  pms_clk_en_t CLK_EN;
  logic [4:0] MODE_STATE;
  pms_row_t r;
  int fails = 0, num_checks = 0, cyc = 0, n;

  always #12.5 MCLK = ~MCLK;

  pms_sequencer #(.RAIL_CYCLES(RAIL), .FORCE_CYCLES(FORCE)) dut_u (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .RESUME_RESET_N(RESUME_RESET_N),
    .POWER_GOOD(POWER_GOOD), .POWER_BUTTON_N(POWER_BUTTON_N),
    .AUTO_ON_STRAP(AUTO_ON_STRAP), .MODE_REQ(MODE_REQ), .MODE_REQ_VALID(MODE_REQ_VALID),
    .PCLK_GATE_EN(PCLK_GATE_EN), .WAKE_SEL(WAKE_SEL), .WAKE_EVT(WAKE_EVT),
    .SYS_IRQ(SYS_IRQ), .RESET_WAKE(RESET_WAKE), .MODE_REQ_READY(MODE_REQ_READY),
    .CLK_EN(CLK_EN), .SWITCH_POWER_ENABLE(SWITCH_POWER_ENABLE),
    .CORE_RAIL_POWER_ENABLE(CORE_RAIL_POWER_ENABLE), .SWITCH_RESET(SWITCH_RESET),
    .SHUTDOWN_FLAG(SHUTDOWN_FLAG), .MODE_STATE(MODE_STATE));

  pms_partner #(.PG_DLY(PG)) part_u (.clk(MCLK), .strap(AUTO_ON_STRAP), .sw_en(SWITCH_POWER_ENABLE),
    .pg(POWER_GOOD), .btn(POWER_BUTTON_N));

  task automatic print_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic req(input pms_req_t c, input logic rdy, input logic [4:0] st);
    @(posedge MCLK);
    MODE_REQ <= c;
    MODE_REQ_VALID <= 1'b1;
    #1 chk(MODE_REQ_READY, rdy, "ready");
    @(posedge MCLK);
    MODE_REQ_VALID <= 1'b0;
    #1 chk(MODE_STATE, st, "state");
  endtask

  task automatic evt(input logic [2:0] e, input logic irq);
    @(posedge MCLK);
    WAKE_EVT <= e;
    SYS_IRQ <= irq;
    @(posedge MCLK);
    WAKE_EVT <= 3'h0;
    SYS_IRQ <= 1'b0;
  endtask

  // seen collects any switch reset shown while coming back
  task automatic wait_normal;
    seen = 1'b0;
    n = 0;
    #1;
    while (MODE_STATE !== 5'h01 && n < 60)
    begin
      @(posedge MCLK);
      #1 seen = seen | SWITCH_RESET;
      n++;
    end
  endtask

  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (20) @(posedge MCLK);
    SYS_RST <= 1'b0;
    RESUME_RESET_N <= 1'b1;
    #1 chk(SWITCH_POWER_ENABLE, 1'b0, "sw in reset");
    chk(CLK_EN, 9'h1FF, "clocks in reset");
    repeat (2) @(posedge MCLK);
    #1 chk(CLK_EN, 9'h1A5, "gated clocks");
    chk(CORE_RAIL_POWER_ENABLE, 1'b0, "rail off");
    fork
      part_u.press(30);
      begin
        @(negedge POWER_BUTTON_N);
        n = 0;
        while (CORE_RAIL_POWER_ENABLE !== 1'b1 && n < 40)
        begin
          @(posedge MCLK);
          #1 n++;
        end
      end
    join
    chk(n >= RAIL * 9 / 10 && n <= RAIL * 11 / 10, 1'b1, "rail delay");
    foreach (rows[i])
    begin
      r = rows[i];
      @(posedge MCLK);
      WAKE_SEL <= r.wsel;
      req(r.req, 1'b1, r.st);
      chk(CLK_EN, r.ck, "mode clocks");
      chk(SWITCH_POWER_ENABLE, r.sw, "mode power");
      req(PMS_REQ_IDLE, 1'b0, r.st);
      if (r.wk != 2'h0)
      begin
        evt(~r.wsel, 1'b0);
        #1 chk(MODE_STATE, r.st, "unselected wake");
      end
      if (r.wk == 2'h2)
        part_u.press(30);
      else
        evt((r.wk == 2'h1) ? r.wsel : 3'h0, r.wk == 2'h0);
      wait_normal();
      chk(MODE_STATE, 5'h01, "woke");
      chk(seen, r.req >= PMS_REQ_SUSPEND, "wake reset");
      chk(n > PG, r.req >= PMS_REQ_SUSPEND, "power good wait");
      @(posedge MCLK);
      #1 chk(SWITCH_RESET, 1'b0, "reset released");
      chk(SHUTDOWN_FLAG, r.flag, "status");
      chk(CLK_EN, 9'h1A5, "clocks back");
    end
    @(posedge MCLK);
    RESET_WAKE <= 1'b1;
    req(PMS_REQ_SLEEP, 1'b1, 5'h04);
    evt(3'h4, 1'b0);
    #1 chk(SWITCH_RESET, 1'b1, "reset wake");
    chk(MODE_STATE, 5'h01, "reset wake resumed");
    @(posedge MCLK);
    RESET_WAKE <= 1'b0;
    #1 chk(SWITCH_RESET, 1'b0, "reset wake released");
    part_u.press(120);
    #1 chk(MODE_STATE, 5'h08, "forced off");
    chk(SHUTDOWN_FLAG, 1'b1, "forced flag");
    chk(SWITCH_POWER_ENABLE, 1'b0, "forced power");
    @(posedge MCLK);
    RESUME_RESET_N <= 1'b0;
    AUTO_ON_STRAP <= 1'b1;
    repeat (3) @(posedge MCLK);
    RESUME_RESET_N <= 1'b1;
    #1 chk(SWITCH_POWER_ENABLE, 1'b0, "sw held off");
    repeat (4) @(posedge MCLK);
    #1 chk(CORE_RAIL_POWER_ENABLE, 1'b1, "auto rail");
    print_verdict();
  end
endmodule // tb
